// [logic/async_event_counter_regs.vh]
// Register offsets, field positions and reset values of the event counter
`ifndef ASYNC_EVENT_COUNTER_REGS_VH
`define ASYNC_EVENT_COUNTER_REGS_VH

// ----------------------------------------------------------------------------
// Register indices on the register port
// ----------------------------------------------------------------------------
`define AEC_OFS_PWM_COMPARE_HIGH 4'h0
`define AEC_OFS_PWM_COMPARE_LOW  4'h1
`define AEC_OFS_PWM_DATA_HIGH    4'h2
`define AEC_OFS_PWM_DATA_LOW     4'h3
`define AEC_OFS_EDGE_SELECT      4'h4
`define AEC_OFS_CLOCK_CONTROL    4'h5
`define AEC_OFS_CONTROL_STATUS   4'h6
`define AEC_OFS_COUNT_HIGH       4'h7
`define AEC_OFS_COUNT_LOW        4'h8
`define AEC_OFS_IRQ_FLAGS        4'h9
`define AEC_OFS_IRQ_ENABLES      4'hA

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AEC_RST_PWM_COMPARE 8'hFF
`define AEC_RST_ZERO        8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
// edge_select
`define AEC_ES_HIGH_MSB  7
`define AEC_ES_HIGH_LSB  6
`define AEC_ES_LOW_MSB   5
`define AEC_ES_LOW_LSB   4
`define AEC_ES_GATE_MSB  3
`define AEC_ES_GATE_LSB  2
`define AEC_ES_PWM_EN    1
// counter_clock_control
`define AEC_CC_HIGH_MSB  7
`define AEC_CC_HIGH_LSB  6
`define AEC_CC_LOW_MSB   5
`define AEC_CC_LOW_LSB   4
`define AEC_CC_PWM_MSB   3
`define AEC_CC_PWM_LSB   1
// counter_control_status
`define AEC_CS_OVH       7
`define AEC_CS_OVL       6
`define AEC_CS_RSVD      5
`define AEC_CS_SPLIT     4
`define AEC_CS_HIGH_COUNT_ENABLE      3
`define AEC_CS_LOW_COUNT_ENABLE      2
`define AEC_CS_HIGH_RESET_RELEASE      1
`define AEC_CS_LOW_RESET_RELEASE      0
// irq_flags / irq_enables
`define AEC_IRQ_COUNTER  0
`define AEC_IRQ_GATE     1

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define AEC_EDGE_FALL    2'b00
`define AEC_EDGE_RISE    2'b01
`define AEC_EDGE_BOTH    2'b10
`define AEC_CLK_PIN      2'b00

`endif

// [logic/async_event_counter.v]
// Asynchronous event counter: two 8-bit counters, prescalers, gating PWM
`timescale 1ns/1ps
`default_nettype none
`include "async_event_counter_regs.vh"

// Functional notes
// - Event pin edge select: 00 falling, 01 rising, 10 both, 11 prohibited.
// - Gate pin edge select: 00 falling, 01 rising, 10 both; 11 never written.
// - PWM enable 0 halts PWM and gates by pin; 1 runs PWM gating.
// - High clock select: 00 pin, 01 clk/2, 10 clk/4, 11 clk/8.
// - Low clock select: 00 pin, 01 clk/2, 10 clk/4, 11 clk/8.
// - PWM clock: 000 /2, 001 /4, 010 /8, 011 /16, 1X0 /32, 1X1 /64.
// - High overflow flag sets when high counter wraps FF to 00.
// - Low overflow flag sets on low wrap only in split mode.
// - Overflow flag clears by writing 0 after reading 1; writing 1 ignored.
// - Split bit 0 chains counters to 16 bits; 1 gives two 8-bit counters.
// - Count enable 0 blocks counter clock and holds value; 1 passes it.
// - Reset release bit 0 holds counter at zero; 1 releases it.
// - Counters read-only, reset zero; chained high counts low carries.
// - Counting only while selected gating signal is high.
// - In 16-bit mode low clock and edge selects drive the pair.
// - After reset: 16-bit mode, low pin, falling edge.
// - 16-bit wrap FFFF to 0000 sets high overflow flag, keeps counting.
// - Any overflow sets counter irq flag; request only when enabled.
// - PWM data registers write-only, reset to zero.
// - PWM low for data+1 periods, high until compare+1 periods.
// - Selected gating edge sets gate irq flag; request only when enabled.
// - PWM compare registers set the period and reset to all ones.
module async_event_counter (
  // Clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // Register port
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Event and gate pins
  input  wire       event_pin_high,
  input  wire       event_pin_low,
  input  wire       gate_interrupt_pin,
  // Interrupt requests and PWM waveform
  output wire       counter_irq,
  output wire       gate_irq,
  output reg        gating_pwm_output
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Edge match against a two-bit select; code 11 senses nothing
  // Sensing nothing on the prohibited code keeps a stray write harmless
  function edge_hit;
    input       prev;
    input       cur;
    input [1:0] sel;
    begin
      case (sel)
        `AEC_EDGE_FALL: edge_hit = prev & ~cur;
        `AEC_EDGE_RISE: edge_hit = ~prev & cur;
        `AEC_EDGE_BOTH: edge_hit = prev ^ cur;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Prescaler tick for divide by two to the power k
  // All rates come from one free counter, so their ticks stay aligned
  function div_tick;
    input [5:0] cnt;
    input [2:0] k;
    begin
      case (k)
        3'h1:    div_tick = cnt[0];
        3'h2:    div_tick = &cnt[1:0];
        3'h3:    div_tick = &cnt[2:0];
        3'h4:    div_tick = &cnt[3:0];
        3'h5:    div_tick = &cnt[4:0];
        3'h6:    div_tick = &cnt[5:0];
        default: div_tick = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  reg  [1:0] rst_sync_q;
  wire       rst_n;
  reg  [2:0] sync_h_q;
  reg  [2:0] sync_l_q;
  reg  [2:0] sync_g_q;
  reg        lvl_h_q;
  reg        lvl_l_q;
  reg        lvl_g_q;
  reg        lvl_h_prev_q;
  reg        lvl_l_prev_q;
  reg        lvl_g_prev_q;
  // Selected gating level, declared here as the edge history samples it
  wire       gate_lvl;

  assign rst_n = rst_sync_q[1];

  // Reset asserts at once, releases two edges later
  // Logic beyond this point sees only the released copy of reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Three-stage pin capture; a level is accepted once stages two and three agree
  // Limitation: each pin phase must last three clocks or an edge may vanish
  // Counting therefore needs the system clock running; no pin-clocked path
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_h_q     <= 3'h0;
      sync_l_q     <= 3'h0;
      sync_g_q     <= 3'h0;
      lvl_h_q      <= 1'b0;
      lvl_l_q      <= 1'b0;
      lvl_g_q      <= 1'b0;
      lvl_h_prev_q <= 1'b0;
      lvl_l_prev_q <= 1'b0;
      lvl_g_prev_q <= 1'b0;
    end else begin
      sync_h_q     <= {sync_h_q[1:0], event_pin_high};
      sync_l_q     <= {sync_l_q[1:0], event_pin_low};
      sync_g_q     <= {sync_g_q[1:0], gate_interrupt_pin};
      if (sync_h_q[1] == sync_h_q[2]) lvl_h_q <= sync_h_q[2];
      if (sync_l_q[1] == sync_l_q[2]) lvl_l_q <= sync_l_q[2];
      if (sync_g_q[1] == sync_g_q[2]) lvl_g_q <= sync_g_q[2];
      lvl_h_prev_q <= lvl_h_q;
      lvl_l_prev_q <= lvl_l_q;
      lvl_g_prev_q <= gate_lvl;
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  reg  [7:0] cmp_high_q;
  reg  [7:0] cmp_low_q;
  reg  [7:0] dat_high_q;
  reg  [7:0] dat_low_q;
  reg  [7:0] edge_sel_q;
  reg  [7:0] clk_ctl_q;
  reg  [5:0] ctl_q;      // reserved, split, enables and releases (bits 5..0)
  reg        ovh_q;
  reg        ovl_q;
  reg        ovh_armed_q;
  reg        ovl_armed_q;
  reg        cnt_irq_flag_q;
  reg        gate_irq_flag_q;
  reg  [1:0] irq_en_q;
  reg  [7:0] count_high_q;
  reg  [7:0] count_low_q;

  wire       pwm_en      = edge_sel_q[`AEC_ES_PWM_EN];
  wire       split       = ctl_q[`AEC_CS_SPLIT];
  wire       cue_h       = ctl_q[`AEC_CS_HIGH_COUNT_ENABLE];
  wire       cue_l       = ctl_q[`AEC_CS_LOW_COUNT_ENABLE];
  wire       rel_h       = ctl_q[`AEC_CS_HIGH_RESET_RELEASE];
  wire       rel_l       = ctl_q[`AEC_CS_LOW_RESET_RELEASE];
  wire       wr_status   = wr && (addr == `AEC_OFS_CONTROL_STATUS);
  wire       rd_status   = rd && (addr == `AEC_OFS_CONTROL_STATUS);
  wire       wr_irq_flag = wr && (addr == `AEC_OFS_IRQ_FLAGS);

  // --------------------------------------------------------------------------
  // Prescaler and gating PWM
  // --------------------------------------------------------------------------
  reg  [5:0]  presc_q;
  reg  [15:0] pwm_cnt_q;
  wire [15:0] pwm_cmp = {cmp_high_q, cmp_low_q};
  wire [15:0] pwm_dat = {dat_high_q, dat_low_q};
  wire [2:0]  pwm_sel = clk_ctl_q[`AEC_CC_PWM_MSB:`AEC_CC_PWM_LSB];
  reg  [2:0]  pwm_k;
  wire        pwm_tick;

  // Middle select bit is ignored for the two slowest rates
  always @* begin
    if (pwm_sel[2]) begin
      pwm_k = pwm_sel[0] ? 3'h6 : 3'h5;
    end else begin
      pwm_k = {1'b0, pwm_sel[1:0]} + 3'h1;
    end
  end

  assign pwm_tick = div_tick(presc_q, pwm_k);
  // Gating source follows the PWM enable
  assign gate_lvl = pwm_en ? gating_pwm_output : lvl_g_q;

  // Free prescaler; PWM runs low for data+1 ticks then high until compare+1
  // Data and compare are not double buffered; changing them while running
  // could give one malformed period, hence software halts the PWM first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q           <= 6'h00;
      pwm_cnt_q         <= 16'h0000;
      gating_pwm_output <= 1'b0;
    end else begin
      presc_q <= presc_q + 6'h01;
      if (!pwm_en) begin
        pwm_cnt_q         <= 16'h0000;
        gating_pwm_output <= 1'b0;
      end else if (pwm_tick) begin
        if (pwm_cnt_q >= pwm_cmp) begin
          pwm_cnt_q         <= 16'h0000;
          gating_pwm_output <= 1'b0;
        end else begin
          pwm_cnt_q         <= pwm_cnt_q + 16'h0001;
          gating_pwm_output <= (pwm_cnt_q >= pwm_dat);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Count events
  // --------------------------------------------------------------------------
  wire [1:0] ck_h = clk_ctl_q[`AEC_CC_HIGH_MSB:`AEC_CC_HIGH_LSB];
  wire [1:0] ck_l = clk_ctl_q[`AEC_CC_LOW_MSB:`AEC_CC_LOW_LSB];
  wire       src_h;
  wire       src_l;
  wire       tick_l;
  wire       tick_h;
  wire       wrap_l;
  wire       wrap_h;
  wire       gate_edge;

  // Pin edge or prescaler, per clock select
  assign src_h = (ck_h == `AEC_CLK_PIN) ?
                 edge_hit(lvl_h_prev_q, lvl_h_q,
                          edge_sel_q[`AEC_ES_HIGH_MSB:`AEC_ES_HIGH_LSB]) :
                 div_tick(presc_q, {1'b0, ck_h});
  assign src_l = (ck_l == `AEC_CLK_PIN) ?
                 edge_hit(lvl_l_prev_q, lvl_l_q,
                          edge_sel_q[`AEC_ES_LOW_MSB:`AEC_ES_LOW_LSB]) :
                 div_tick(presc_q, {1'b0, ck_l});

  // Gate, enable and release all must pass before a count
  // An event meeting a closed gate is dropped, not held over
  assign tick_l = src_l && gate_lvl && cue_l && rel_l;
  assign wrap_l = tick_l && (count_low_q == 8'hFF);
  // Chained mode feeds the low carry into the high counter
  assign tick_h = (split ? (src_h && gate_lvl) : wrap_l) && cue_h && rel_h;
  assign wrap_h = tick_h && (count_high_q == 8'hFF);
  assign gate_edge = edge_hit(lvl_g_prev_q, gate_lvl,
                              edge_sel_q[`AEC_ES_GATE_MSB:`AEC_ES_GATE_LSB]);

  // Counters: held at zero while not released, wrap and carry on
  // The two bytes are read in separate accesses, so a carry between
  // them tears the 16-bit value; software stops counting before reading
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_q  <= `AEC_RST_ZERO;
      count_high_q <= `AEC_RST_ZERO;
    end else begin
      if (!rel_l) count_low_q <= `AEC_RST_ZERO;
      else if (tick_l) count_low_q <= count_low_q + 8'h01;
      if (!rel_h) count_high_q <= `AEC_RST_ZERO;
      else if (tick_h) count_high_q <= count_high_q + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes and flags
  // --------------------------------------------------------------------------
  // Reserved bits are plain storage; software keeps them at zero
  // PWM data is write-only; the read mux has no entry for it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_high_q <= `AEC_RST_PWM_COMPARE;
      cmp_low_q  <= `AEC_RST_PWM_COMPARE;
      dat_high_q <= `AEC_RST_ZERO;
      dat_low_q  <= `AEC_RST_ZERO;
      edge_sel_q <= `AEC_RST_ZERO;
      clk_ctl_q  <= `AEC_RST_ZERO;
      ctl_q      <= 6'h00;
      irq_en_q   <= 2'b00;
    end else if (wr) begin
      case (addr)
        `AEC_OFS_PWM_COMPARE_HIGH: cmp_high_q <= wdata;
        `AEC_OFS_PWM_COMPARE_LOW:  cmp_low_q  <= wdata;
        `AEC_OFS_PWM_DATA_HIGH:    dat_high_q <= wdata;
        `AEC_OFS_PWM_DATA_LOW:     dat_low_q  <= wdata;
        `AEC_OFS_EDGE_SELECT:      edge_sel_q <= wdata;
        `AEC_OFS_CLOCK_CONTROL:    clk_ctl_q  <= wdata;
        `AEC_OFS_CONTROL_STATUS:   ctl_q      <= wdata[5:0];
        `AEC_OFS_IRQ_ENABLES:      irq_en_q   <= wdata[1:0];
        default:                   ctl_q      <= ctl_q;
      endcase
    end
  end

  // Overflow flags clear only by 0 after a read of 1; a new overflow wins
  // A read that returns 1 arms, any status write disarms, so a flag
  // that sets after the read survives the clearing write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovh_q           <= 1'b0;
      ovl_q           <= 1'b0;
      ovh_armed_q     <= 1'b0;
      ovl_armed_q     <= 1'b0;
      cnt_irq_flag_q  <= 1'b0;
      gate_irq_flag_q <= 1'b0;
    end else begin
      if (wrap_h) begin
        ovh_q <= 1'b1;
      end else if (wr_status && !wdata[`AEC_CS_OVH] && ovh_armed_q) begin
        ovh_q <= 1'b0;
      end
      if (wrap_l && split) begin
        ovl_q <= 1'b1;
      end else if (wr_status && !wdata[`AEC_CS_OVL] && ovl_armed_q) begin
        ovl_q <= 1'b0;
      end
      if (rd_status) begin
        ovh_armed_q <= ovh_q;
        ovl_armed_q <= ovl_q;
      end else if (wr_status) begin
        ovh_armed_q <= 1'b0;
        ovl_armed_q <= 1'b0;
      end
      if (wrap_h || (wrap_l && split)) begin
        cnt_irq_flag_q <= 1'b1;
      end else if (wr_irq_flag && !wdata[`AEC_IRQ_COUNTER]) begin
        cnt_irq_flag_q <= 1'b0;
      end
      if (gate_edge) begin
        gate_irq_flag_q <= 1'b1;
      end else if (wr_irq_flag && !wdata[`AEC_IRQ_GATE]) begin
        gate_irq_flag_q <= 1'b0;
      end
    end
  end

  // Requests are forwarded only when enabled
  assign counter_irq = cnt_irq_flag_q & irq_en_q[`AEC_IRQ_COUNTER];
  assign gate_irq    = gate_irq_flag_q & irq_en_q[`AEC_IRQ_GATE];

  // --------------------------------------------------------------------------
  // Read data, valid only in the cycle after the strobe
  // --------------------------------------------------------------------------
  // Zero outside the answer cycle lets several blocks share an OR read bus
  // Reads have no side effect apart from arming the overflow flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `AEC_OFS_PWM_COMPARE_HIGH: rdata <= cmp_high_q;
        `AEC_OFS_PWM_COMPARE_LOW:  rdata <= cmp_low_q;
        `AEC_OFS_EDGE_SELECT:      rdata <= edge_sel_q;
        `AEC_OFS_CLOCK_CONTROL:    rdata <= clk_ctl_q;
        `AEC_OFS_CONTROL_STATUS:   rdata <= {ovh_q, ovl_q, ctl_q};
        `AEC_OFS_COUNT_HIGH:       rdata <= count_high_q;
        `AEC_OFS_COUNT_LOW:        rdata <= count_low_q;
        `AEC_OFS_IRQ_FLAGS:        rdata <= {6'h00, gate_irq_flag_q, cnt_irq_flag_q};
        `AEC_OFS_IRQ_ENABLES:      rdata <= {6'h00, irq_en_q};
        default:                   rdata <= 8'h00; // Write-only and unmapped
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [testbench/async_event_counter_props.sv]
// Port-level assertions for the asynchronous event counter
`timescale 1ns/1ps
`default_nettype none
module async_event_counter_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Requests and waveform
  input wire logic       counter_irq,
  input wire logic       gate_irq,
  input wire logic       gating_pwm_output
);
  logic       pwm_en_q;
  logic [1:0] off_q;
  logic [1:0] ien_q;
  logic       cmp_wr_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Shadows of what software wrote, so masks can be judged from outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_en_q <= 1'b0;
      ien_q    <= 2'b00;
      cmp_wr_q <= 1'b0;
      off_q    <= 2'd0;
    end else begin
      if (wr && addr == 4'h4) pwm_en_q <= wdata[1];
      if (wr && addr == 4'hA) ien_q <= wdata[1:0];
      if (wr && addr[3:1] == 3'b000) cmp_wr_q <= 1'b1;
      // Saturates, so a long halt never wraps back to zero
      off_q <= pwm_en_q ? 2'd0 : ((off_q == 2'd3) ? off_q : off_q + 2'd1);
    end
  end

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data seen outside a read answer");
  a_wo_read_zero: assert property (rd && addr[3:1] == 3'b001 |=> rdata == 8'h00)
    else $error("write-only register returned data");
  a_unmapped_zero: assert property (rd && addr > 4'hA |=> rdata == 8'h00)
    else $error("unmapped index returned data");
  a_cmp_reset: assert property (rd && addr[3:1] == 3'b000 && !cmp_wr_q |=> rdata == 8'hFF)
    else $error("compare register not at all ones");
  a_pwm_off: assert property (off_q == 2'd3 |-> !gating_pwm_output)
    else $error("waveform high while halted");
  a_pwm_rise_en: assert property ($rose(gating_pwm_output) |-> $past(pwm_en_q))
    else $error("waveform rose while disabled");
  a_cnt_irq_mask: assert property (!ien_q[0] && !$past(ien_q[0]) |-> !counter_irq)
    else $error("counter request while masked");
  a_cnt_irq_rise: assert property ($rose(counter_irq) |-> ien_q[0])
    else $error("counter request rose while masked");
  a_gate_irq_mask: assert property ((!ien_q[1]) [*2] |-> !gate_irq)
    else $error("gate request while masked");
endmodule

bind async_event_counter async_event_counter_props u_props (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .counter_irq(counter_irq), .gate_irq(gate_irq),
  .gating_pwm_output(gating_pwm_output));
`default_nettype wire

// [testbench/event_source_model.sv]
// Outside event source: two event pins and the gate pin
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  // Pins toward the counter
  output var logic ev_high,
  output var logic ev_low,
  output var logic gate
);
  // Idle high, so a first falling edge is a real event
  initial begin
    ev_high = 1'b1;
    ev_low  = 1'b1;
    gate    = 1'b1;
  end
  // 50 ns phases clear the 3-cycle floor and stay off the clock edges
  task automatic pulses(input int pin, input int cnt);
    #2;
    repeat (cnt) begin
      if (pin == 1) ev_high = 1'b0;
      else ev_low = 1'b0;
      #50;
      if (pin == 1) ev_high = 1'b1;
      else ev_low = 1'b1;
      #50;
    end
    #100;
  endtask
  // Gate level change, then time for the synchroniser to settle
  task automatic set_gate(input logic v);
    #2 gate = v;
    #100;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the asynchronous event counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  wire  [7:0] rdata;
  wire        ev_high;
  wire        ev_low;
  wire        gate;
  wire        counter_irq;
  wire        gate_irq;
  wire        pwm;
  int         n_fail = 0;
  int         n_tests = 0;
  int         n;
  int         d;
  logic [7:0] v;

  // 100 MHz clock
  always #5 clk = ~clk;

  async_event_counter u_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .event_pin_high(ev_high), .event_pin_low(ev_low),
    .gate_interrupt_pin(gate), .counter_irq(counter_irq), .gate_irq(gate_irq),
    .gating_pwm_output(pwm));
  event_source_model u_src (.ev_high(ev_high), .ev_low(ev_low), .gate(gate));

  // Verdict, reached from the end of the run or from a wait that ran out
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] dv);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dv;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] dv);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 dv = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] got;
    rd_reg(a, got);
    chk(got, exp);
  endtask
  // Bounded wait for a waveform level, counting cycles
  task automatic wait_pwm(input logic lvl, output int cnt);
    cnt = 0;
    while (pwm !== lvl) begin
      @(posedge clk);
      #1 cnt++;
      if (cnt > 1000) begin
        n_fail++;
        close_out();
      end
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset map, unmapped indices included
    rd_chk(4'h0, 8'hFF);
    rd_chk(4'h1, 8'hFF);
    for (int a = 2; a < 16; a++) rd_chk(a[3:0], 8'h00);
    wr_reg(4'h7, 8'h55);
    wr_reg(4'h8, 8'hAA);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'h8, 8'h00);
    // Held in reset, then default chained falling-edge counting
    wr_reg(4'h6, 8'h0C);
    u_src.pulses(0, 4);
    rd_chk(4'h8, 8'h00);
    wr_reg(4'h6, 8'h0F);
    u_src.pulses(0, 5);
    rd_chk(4'h8, 8'h05);
    wr_reg(4'h6, 8'h0B);
    u_src.pulses(0, 3);
    rd_chk(4'h8, 8'h05);
    wr_reg(4'h6, 8'h0F);
    u_src.set_gate(1'b0);
    u_src.pulses(0, 3);
    u_src.set_gate(1'b1);
    rd_chk(4'h8, 8'h05);
    // Edge codes 00, 01 and 10 on both pins, split mode
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) begin
        wr_reg(4'h4, 8'(c << ((p == 1) ? 6 : 4)));
        wr_reg(4'h6, 8'h10);
        wr_reg(4'h6, 8'h1F);
        u_src.pulses(p, 3);
        rd_chk((p == 1) ? 4'h7 : 4'h8, (c == 2) ? 8'h06 : 8'h03);
        rd_chk((p == 1) ? 4'h8 : 4'h7, 8'h00);
      end
    end
    // Gate edge codes and the gate request mask
    wr_reg(4'hA, 8'h02);
    for (int c = 0; c < 3; c++) begin
      wr_reg(4'h4, 8'(c << 2));
      wr_reg(4'h9, 8'h00);
      u_src.set_gate(1'b0);
      rd_chk(4'h9, (c != 1) ? 8'h02 : 8'h00);
      wr_reg(4'h9, 8'h00);
      u_src.set_gate(1'b1);
      rd_chk(4'h9, (c != 0) ? 8'h02 : 8'h00);
    end
    chk({7'h00, gate_irq}, 8'h01);
    wr_reg(4'hA, 8'h00);
    chk({7'h00, gate_irq}, 8'h00);
    wr_reg(4'h9, 8'h00);
    wr_reg(4'h4, 8'h00);
    // Prescaled clocks: about 40 ticks either way
    for (int k = 1; k < 4; k++) begin
      wr_reg(4'h5, 8'(k * 8'h50));
      wr_reg(4'h6, 8'h10);
      wr_reg(4'h6, 8'h1F);
      repeat (40 << k) @(posedge clk);
      wr_reg(4'h6, 8'h13);
      rd_reg(4'h7, v);
      chk(8'(v > 8'd37 && v < 8'd44), 8'h01);
      rd_reg(4'h8, v);
      chk(8'(v > 8'd37 && v < 8'd44), 8'h01);
    end
    // Split overflow of both counters, flags and request
    wr_reg(4'h5, 8'h50);
    wr_reg(4'hA, 8'h01);
    wr_reg(4'h6, 8'h10);
    wr_reg(4'h6, 8'h1F);
    repeat (600) @(posedge clk);
    wr_reg(4'h6, 8'h13);
    chk({7'h00, counter_irq}, 8'h01);
    wr_reg(4'hA, 8'h00);
    chk({7'h00, counter_irq}, 8'h00);
    rd_chk(4'h9, 8'h01);
    wr_reg(4'h9, 8'h00);
    wr_reg(4'h6, 8'hD3);
    wr_reg(4'h6, 8'h13);
    rd_chk(4'h6, 8'hD3);
    wr_reg(4'h6, 8'h13);
    rd_chk(4'h6, 8'h13);
    // Chained pair: carry reaches the high counter, no low flag
    wr_reg(4'h5, 8'h10);
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h6, 8'h0F);
    repeat (600) @(posedge clk);
    wr_reg(4'h6, 8'h03);
    rd_chk(4'h7, 8'h01);
    rd_chk(4'h6, 8'h03);
    // Waveform: data 1, compare 4, over every clock code
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h04);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h3, 8'h01);
    rd_chk(4'h3, 8'h00);
    for (int c = 0; c < 8; c++) begin
      d = (c >= 4) ? ((c % 2 == 1) ? 64 : 32) : (2 << c);
      wr_reg(4'h4, 8'h00);
      wr_reg(4'h5, 8'(c << 1));
      wr_reg(4'h4, 8'h02);
      wait_pwm(1'b1, n);
      wait_pwm(1'b0, n);
      chk(8'(n), 8'(3 * d));
      wait_pwm(1'b1, n);
      chk(8'(n), 8'(2 * d));
    end
    wr_reg(4'h4, 8'h00);
    repeat (4) @(posedge clk);
    chk({7'h00, pwm}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
